// ===== rtl/bhcc_pkg.sv
// Shared constants of the Hall commutation controller: timing, register map and fields.
// Assumes a 125 MHz block clock and a 32-bit classic Wishbone register port.
package bhcc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 8;
  localparam int unsigned SPEED_PULSE_OUT_MIN_NS    = 300;
  localparam int unsigned SPEED_PULSE_OUT_CYCLES    = (SPEED_PULSE_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ONESHOT_NS     = 100000;
  localparam int unsigned ONESHOT_CYCLES = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          SPEED_PULSE_OUT_W         = 6;
  localparam int          ONESHOT_W      = 16;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_STATUS     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;

  localparam int         CTRL_W           = 5;
  localparam int         CTRL_ENABLE      = 0;
  localparam int         CTRL_FORWARD     = 1;
  localparam int         CTRL_BOTTOM_ONLY = 2;
  localparam int         CTRL_SPACING_60  = 3;
  localparam int         CTRL_BRAKE       = 4;
  localparam logic [4:0] CTRL_RESET       = 5'h1f;

  localparam int ST_HALL_LSB = 0;
  localparam int ST_INVALID  = 3;
  localparam int ST_OC       = 4;
  localparam int ST_FAULT    = 5;
  localparam int ST_UVLO     = 6;

  localparam int         IRQ_W          = 4;
  localparam int         IRQ_HALL       = 0;
  localparam int         IRQ_OC         = 1;
  localparam int         IRQ_INVALID    = 2;
  localparam int         IRQ_FAULT      = 3;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

endpackage

// ===== rtl/bhcc_speed_pulse_out.sv
// Speed pulse generator: one stretched pulse per Hall code change.
// Assumes Hall inputs synchronous to clk_i.
`timescale 1ns/10ps
module bhcc_speed_pulse_out (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] hall_i,
  output logic            pulse_o,
  output logic            edge_o
);
  logic [2:0]                  hall_prev;
  logic                        primed;
  logic [bhcc_pkg::SPEED_PULSE_OUT_W-1:0] count;

  // The first sample after reset only primes the history, so reset gives no pulse.
  assign edge_o  = primed && (hall_i != hall_prev);
  assign pulse_o = (count != '0);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hall_prev <= 3'h0;
      primed    <= 1'b0;
    end
    else
    begin
      hall_prev <= hall_i;
      primed    <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= '0;
    else if (edge_o)
      count <= bhcc_pkg::SPEED_PULSE_OUT_W'(bhcc_pkg::SPEED_PULSE_OUT_CYCLES);
    else if (count != '0)
      count <= count - 1'b1;
  end

  int unsigned run_len;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !pulse_o)
      run_len <= 0;
    else
      run_len <= run_len + 1;
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_speed_pulse_out_start: assert property (edge_o |=> pulse_o)
    else $error("speed pulse did not start after a Hall change");
  chk_speed_pulse_out_width: assert property ($fell(pulse_o) |-> run_len >= bhcc_pkg::SPEED_PULSE_OUT_CYCLES)
    else $error("speed pulse shorter than minimum width");
  cov_speed_pulse_out_pulse: cover property (edge_o ##1 pulse_o);
endmodule

// ===== rtl/bhcc_oneshot.sv
// Overcurrent one-shot: timed shutdown, then hold while overcurrent persists.
// Assumes the comparator level is synchronous to clk_i; PERIOD of at least 8.
`timescale 1ns/10ps
module bhcc_oneshot #(
  parameter int unsigned PERIOD = bhcc_pkg::ONESHOT_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic overcurrent_i,
  output logic      shutdown_o,
  output logic      trigger_o
);
  typedef enum logic [1:0] {OS_IDLE, OS_TIMING, OS_HOLD} bhcc_os_state_t;
  bhcc_os_state_t                 state;
  logic [bhcc_pkg::ONESHOT_W-1:0] count;

  assign trigger_o  = (state == OS_IDLE) && overcurrent_i;
  // The raw level also blocks the drives, so the bridge is off one cycle sooner.
  assign shutdown_o = (state != OS_IDLE) || overcurrent_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= OS_IDLE;
      count <= '0;
    end
    else
    begin
      unique case (state)
        OS_IDLE:
        begin
          if (overcurrent_i)
          begin
            state <= OS_TIMING;
            count <= bhcc_pkg::ONESHOT_W'(PERIOD - 1);
          end
        end
        OS_TIMING:
        begin
          if (count == '0)
            state <= overcurrent_i ? OS_HOLD : OS_IDLE;
          else
            count <= count - 1'b1;
        end
        OS_HOLD:
        begin
          if (!overcurrent_i)
            state <= OS_IDLE;
        end
      endcase
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_oneshot_period: assert property (trigger_o |=> (state == OS_TIMING) [*8])
    else $error("one-shot ended too early");
  chk_oneshot_hold: assert property ((state == OS_TIMING) && (count == '0)
                                     && overcurrent_i |=> (state == OS_HOLD) && shutdown_o)
    else $error("persisting overcurrent not held off");
  cov_oneshot_hold: cover property (state == OS_HOLD ##1 state == OS_IDLE);
endmodule

// ===== rtl/bhcc_motor_ctrl.sv
// Top of the Hall commutation controller: six-step decode, protection, registers.
// Assumes all pins synchronous to clk_i and a classic Wishbone master.
//
// Contract
// - Three Hall lines feed the decode.
// - Spacing select: one picks 60, zero 120.
// - Enable low forces all gate drives off.
// - Direction low inverts Hall code for reverse.
// - Quadrature select picks bottom-only or both PWM-gated.
// - PWM low switches the selected drives off.
// - Brake high: tops off, bottoms on.
// - Brake low returns control to the decode.
// - Each Hall change gives a stretched speed pulse.
// - Fault low on disable, undervoltage, invalid, overcurrent.
// - Invalid Hall code shuts drives down, reports fault.
// - Overcurrent fires one-shot that blocks all drives.
// - Persisting overcurrent keeps drives off until clear.
// - Brake keeps bottoms on despite disable, invalid, overcurrent.
`timescale 1ns/10ps
module bhcc_motor_ctrl #(
  parameter int unsigned ONESHOT_CYCLES = bhcc_pkg::ONESHOT_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        hall_sensor_a_i,
  input  wire logic        hall_sensor_b_i,
  input  wire logic        hall_sensor_c_i,
  input  wire logic        pwm_i,
  input  wire logic        current_limit_i,
  input  wire logic        undervoltage_i,
  output logic             top_drive_phase_a_o,
  output logic             top_drive_phase_b_o,
  output logic             top_drive_phase_c_o,
  output logic             bottom_drive_phase_a_o,
  output logic             bottom_drive_phase_b_o,
  output logic             bottom_drive_phase_c_o,
  output logic             speed_pulse_out_o,
  output logic             speed_pulse_out_oe_n_o,
  output logic             fault_out_o,
  output logic             fault_out_oe_n_o
);

  // ****************************************************************
  // Registers and internal signals
  // ****************************************************************
  logic [bhcc_pkg::CTRL_W-1:0] ctrl;
  logic [bhcc_pkg::IRQ_W-1:0]  irq_status;
  logic [bhcc_pkg::IRQ_W-1:0]  irq_mask;
  logic [bhcc_pkg::IRQ_W-1:0]  irq_event;
  logic [2:0]                  hall_raw;
  logic [2:0]                  hall_adj;
  logic [6:0]                  decoded;
  logic                        code_valid;
  logic                        invalid_q;
  logic                        fault_q;
  logic                        oc_shutdown;
  logic                        oc_trigger;
  logic                        speed_pulse_out_pulse;
  logic                        speed_pulse_out_edge;
  logic [2:0]                  top_q;
  logic [2:0]                  bot_q;
  logic [2:0]                  next_top;
  logic [2:0]                  next_bot;
  logic                        next_fault;
  logic                        wb_req;
  logic                        wr_fire;
  logic [31:0]                 next_rdata;

  // ****************************************************************
  // Commutation decode
  // ****************************************************************
  // Result packs {valid, top A/B/C, bottom A/B/C}, phase A in the high bit.
  function automatic logic [6:0] decode_step(input logic [2:0] code, input logic sp60);
    logic [6:0] r;
    r = 7'h00;
    if (sp60)
    begin
      unique case (code)
        3'h0:    r = {1'b1, 3'h4, 3'h2};
        3'h4:    r = {1'b1, 3'h4, 3'h1};
        3'h6:    r = {1'b1, 3'h2, 3'h1};
        3'h7:    r = {1'b1, 3'h2, 3'h4};
        3'h3:    r = {1'b1, 3'h1, 3'h4};
        3'h1:    r = {1'b1, 3'h1, 3'h2};
        default: r = 7'h00;
      endcase
    end
    else
    begin
      unique case (code)
        3'h5:    r = {1'b1, 3'h4, 3'h2};
        3'h4:    r = {1'b1, 3'h4, 3'h1};
        3'h6:    r = {1'b1, 3'h2, 3'h1};
        3'h2:    r = {1'b1, 3'h2, 3'h4};
        3'h3:    r = {1'b1, 3'h1, 3'h4};
        3'h1:    r = {1'b1, 3'h1, 3'h2};
        default: r = 7'h00;
      endcase
    end
    return r;
  endfunction

  assign hall_raw   = {hall_sensor_a_i, hall_sensor_b_i, hall_sensor_c_i};
  // Inverting the code keeps the invalid pair invalid in both spacings.
  assign hall_adj   = ctrl[bhcc_pkg::CTRL_FORWARD] ? hall_raw : ~hall_raw;
  assign decoded    = decode_step(hall_adj, ctrl[bhcc_pkg::CTRL_SPACING_60]);
  assign code_valid = decoded[6];

  // ****************************************************************
  // Protection and speed pulse blocks
  // ****************************************************************
  bhcc_oneshot #(
    .PERIOD (ONESHOT_CYCLES)
  ) u_oneshot (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .overcurrent_i (current_limit_i),
    .shutdown_o    (oc_shutdown),
    .trigger_o     (oc_trigger)
  );

  bhcc_speed_pulse_out u_speed_pulse_out (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .hall_i  (hall_raw),
    .pulse_o (speed_pulse_out_pulse),
    .edge_o  (speed_pulse_out_edge)
  );

  // ****************************************************************
  // Gate drive selection
  // ****************************************************************
  // Brake outranks every shutdown except undervoltage: with the supply low the
  // bottom gates cannot be driven meaningfully, so everything is released.
  always_comb
  begin
    next_top = 3'h0;
    next_bot = 3'h0;
    if (undervoltage_i)
    begin
      next_top = 3'h0;
      next_bot = 3'h0;
    end
    else if (ctrl[bhcc_pkg::CTRL_BRAKE])
    begin
      next_top = 3'h0;
      next_bot = 3'h7;
    end
    else if (!ctrl[bhcc_pkg::CTRL_ENABLE] || !code_valid || oc_shutdown)
    begin
      next_top = 3'h0;
      next_bot = 3'h0;
    end
    else
    begin
      next_top = decoded[5:3];
      next_bot = decoded[2:0];
      if (!pwm_i)
      begin
        next_bot = 3'h0;
        if (!ctrl[bhcc_pkg::CTRL_BOTTOM_ONLY])
          next_top = 3'h0;
      end
    end
  end

  assign next_fault = !ctrl[bhcc_pkg::CTRL_ENABLE] || undervoltage_i
                      || !code_valid || oc_shutdown;

  for (genvar ph = 0; ph < 3; ph++)
  begin : g_phase
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        top_q[ph] <= 1'b0;
        bot_q[ph] <= 1'b0;
      end
      else
      begin
        top_q[ph] <= next_top[ph];
        bot_q[ph] <= next_bot[ph];
      end
    end
  end

  assign top_drive_phase_a_o    = top_q[2];
  assign top_drive_phase_b_o    = top_q[1];
  assign top_drive_phase_c_o    = top_q[0];
  assign bottom_drive_phase_a_o = bot_q[2];
  assign bottom_drive_phase_b_o = bot_q[1];
  assign bottom_drive_phase_c_o = bot_q[0];

  // Open-drain pins: the level is always low, the enable decides the pull.
  assign speed_pulse_out_o = 1'b0;
  assign fault_out_o       = 1'b0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_out_oe_n_o       <= 1'b1;
      speed_pulse_out_oe_n_o <= 1'b1;
      fault_q                <= 1'b0;
      invalid_q              <= 1'b0;
    end
    else
    begin
      fault_out_oe_n_o       <= !next_fault;
      speed_pulse_out_oe_n_o <= !speed_pulse_out_pulse;
      fault_q                <= next_fault;
      invalid_q              <= !code_valid;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // A write lands on the edge where the master sees ack, never earlier.
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_comb
  begin
    next_rdata = 32'h0;
    unique case (wb_adr_i)
      bhcc_pkg::ADDR_CTRL:       next_rdata[bhcc_pkg::CTRL_W-1:0] = ctrl;
      bhcc_pkg::ADDR_STATUS:
      begin
        next_rdata[bhcc_pkg::ST_HALL_LSB +: 3] = hall_raw;
        next_rdata[bhcc_pkg::ST_INVALID]       = !code_valid;
        next_rdata[bhcc_pkg::ST_OC]            = oc_shutdown;
        next_rdata[bhcc_pkg::ST_FAULT]         = fault_q;
        next_rdata[bhcc_pkg::ST_UVLO]          = undervoltage_i;
      end
      bhcc_pkg::ADDR_IRQ_STATUS: next_rdata[bhcc_pkg::IRQ_W-1:0] = irq_status;
      bhcc_pkg::ADDR_IRQ_MASK:   next_rdata[bhcc_pkg::IRQ_W-1:0] = irq_mask;
      default:                   next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl <= bhcc_pkg::CTRL_RESET;
    else if (wr_fire && wb_adr_i == bhcc_pkg::ADDR_CTRL)
      ctrl <= wb_dat_i[bhcc_pkg::CTRL_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= bhcc_pkg::IRQ_MASK_RESET;
    else if (wr_fire && wb_adr_i == bhcc_pkg::ADDR_IRQ_MASK)
      irq_mask <= wb_dat_i[bhcc_pkg::IRQ_W-1:0];
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_event[bhcc_pkg::IRQ_HALL]    = speed_pulse_out_edge;
  assign irq_event[bhcc_pkg::IRQ_OC]      = oc_trigger;
  assign irq_event[bhcc_pkg::IRQ_INVALID] = !code_valid && !invalid_q;
  assign irq_event[bhcc_pkg::IRQ_FAULT]   = next_fault && !fault_q;

  for (genvar b = 0; b < bhcc_pkg::IRQ_W; b++)
  begin : g_irq
    // A new event beats a simultaneous write-one-to-clear.
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        irq_status[b] <= 1'b0;
      else if (irq_event[b])
        irq_status[b] <= 1'b1;
      else if (wr_fire && wb_adr_i == bhcc_pkg::ADDR_IRQ_STATUS && wb_dat_i[b])
        irq_status[b] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_status & irq_mask);
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic run_ok;
  assign run_ok = ctrl[bhcc_pkg::CTRL_ENABLE] && !ctrl[bhcc_pkg::CTRL_BRAKE]
                  && !undervoltage_i && code_valid && !oc_shutdown;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_brake_shorts: assert property (ctrl[bhcc_pkg::CTRL_BRAKE] && !undervoltage_i
                                     |=> top_q == 3'h0 && bot_q == 3'h7)
    else $error("brake did not short the windings");
  chk_disable_off: assert property (!ctrl[bhcc_pkg::CTRL_ENABLE]
                                    && !ctrl[bhcc_pkg::CTRL_BRAKE]
                                    |=> top_q == 3'h0 && bot_q == 3'h0)
    else $error("disable left a gate drive on");
  chk_invalid_off: assert property (!code_valid && !ctrl[bhcc_pkg::CTRL_BRAKE]
                                    |=> top_q == 3'h0 && bot_q == 3'h0)
    else $error("invalid code left a gate drive on");
  chk_overcurrent_off: assert property (current_limit_i && !ctrl[bhcc_pkg::CTRL_BRAKE]
                                        |=> top_q == 3'h0 && bot_q == 3'h0)
    else $error("overcurrent left a gate drive on");
  chk_fault_causes: assert property (next_fault |=> !fault_out_oe_n_o)
    else $error("fault pin not pulled on a fault cause");
  chk_fault_clear: assert property (!next_fault |=> fault_out_oe_n_o)
    else $error("fault pin pulled without a cause");
  chk_one_pair: assert property (run_ok && pwm_i |=> $onehot(top_q)
                                 && $onehot(bot_q) && (top_q & bot_q) == 3'h0)
    else $error("commutation step not one top and one other bottom");
  chk_pwm_gates: assert property (run_ok && !pwm_i |=> bot_q == 3'h0
                  && (top_q == 3'h0) == !$past(ctrl[bhcc_pkg::CTRL_BOTTOM_ONLY]))
    else $error("PWM gating wrong for quadrature select");
  chk_reverse_map: assert property (run_ok && pwm_i && hall_raw == 3'h0
                  && !ctrl[bhcc_pkg::CTRL_FORWARD] && ctrl[bhcc_pkg::CTRL_SPACING_60]
                  |=> top_q == 3'h2 && bot_q == 3'h4)
    else $error("reverse decode wrong");
  chk_spacing_120: assert property (run_ok && pwm_i && hall_raw == 3'h5
                  && ctrl[bhcc_pkg::CTRL_FORWARD] |=> top_q == 3'h4 && bot_q == 3'h2)
    else $error("decode of code 101 wrong");
  chk_irq_level: assert property (|(irq_status & irq_mask) |=> irq_o)
    else $error("interrupt not raised for a pending unmasked event");

  cov_run_step: cover property (run_ok && pwm_i ##1 speed_pulse_out_edge);
  cov_brake: cover property (ctrl[bhcc_pkg::CTRL_BRAKE] && current_limit_i);
  cov_irq: cover property (irq_o ##1 !irq_o);
endmodule

// ===== tb/bhcc_hall_model.sv
// Hall switch model: turns a rotor step into the three sensor levels.
// Assumes the bench moves pos_i by non-blocking assignment after an edge.
`timescale 1ns/10ps
module bhcc_hall_model (
  input  wire logic       clk_i,
  input  wire logic       sp60_i,
  input  wire logic [2:0] pos_i,
  output logic      [2:0] hall_o
);
  // Steps 6 and 7 give the two codes that cannot occur at that spacing.
  localparam logic [23:0] SEQ60  = 24'h54bfa0;
  localparam logic [23:0] SEQ120 = 24'h1cb5a5;

  // A released switch reads high, so a code bit of one means not pulled.
  always_ff @(posedge clk_i)
  begin
    hall_o <= sp60_i ? SEQ60[3*pos_i +: 3] : SEQ120[3*pos_i +: 3];
  end
endmodule

// ===== tb/bldc_hall_commutation_control_test.sv
// Bench for the Hall commutation controller: pins and register bus.
// Assumes the Hall switch model in place of the sensors; short one-shot.
`timescale 1ns/10ps
module bldc_hall_commutation_control_test;
  // ****
  // Setup
  // ****
  localparam int unsigned OS = 20;
  logic        clk = 0;
  logic        rst = 1;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] q;
  logic        ack;
  logic        irq;
  logic        sp60 = 1;
  logic [2:0]  pos = 3'h0;
  logic [2:0]  hall;
  logic        pwm = 1;
  logic        cl = 0;
  logic        uv = 0;
  wire  [5:0]  g;
  logic        speed_pulse_out_n;
  logic        flt_n;
  logic        speed_pulse_out_lv;
  logic        flt_lv;
  int          fails = 0;
  int          samples_checked = 0;
  logic [5:0]  tab [6] = '{6'h22, 6'h21, 6'h11, 6'h14, 6'h0c, 6'h0a};

  always #4 clk = ~clk;

  bhcc_hall_model u_hall (.clk_i(clk), .sp60_i(sp60), .pos_i(pos), .hall_o(hall));

  bhcc_motor_ctrl #(.ONESHOT_CYCLES(OS)) u_dut (
    .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
    .irq_o(irq), .hall_sensor_a_i(hall[2]), .hall_sensor_b_i(hall[1]),
    .hall_sensor_c_i(hall[0]), .pwm_i(pwm), .current_limit_i(cl), .undervoltage_i(uv),
    .top_drive_phase_a_o(g[5]), .top_drive_phase_b_o(g[4]), .top_drive_phase_c_o(g[3]),
    .bottom_drive_phase_a_o(g[2]), .bottom_drive_phase_b_o(g[1]),
    .bottom_drive_phase_c_o(g[0]), .speed_pulse_out_o(speed_pulse_out_lv),
    .speed_pulse_out_oe_n_o(speed_pulse_out_n), .fault_out_o(flt_lv), .fault_out_oe_n_o(flt_n));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      fails++;
      test_done();
    end
    q = rd;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask

  task automatic gate(input int p, input logic [5:0] e);
    pos <= p[2:0];
    repeat (4) @(posedge clk);
    chk("gates", {26'h0, e}, {26'h0, g});
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_reset;
    repeat (2) @(posedge clk);
    chk("gates", 32'h07, {26'h0, g});
    chk("od_level", 32'h0, {30'h0, speed_pulse_out_lv, flt_lv});
    wb(0, bhcc_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1f, q);
    wb(0, bhcc_pkg::ADDR_IRQ_MASK, 32'h0);
    chk("mask", 32'h0, q);
    wb(0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask

  task automatic t_decode;
    for (int c = 0; c < 4; c++)
    begin
      sp60 <= c[1];
      wb(1, bhcc_pkg::ADDR_CTRL, {28'h0, c[1], 1'b1, c[0], 1'b1});
      for (int p = 0; p < 6; p++)
        gate(p, tab[c[0] ? p : (p + 3) % 6]);
      gate(6, 6'h00);
      chk("fault_n", 32'h0, {31'h0, flt_n});
      gate(7, 6'h00);
    end
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h1f);
    gate(6, 6'h07);
    wb(0, bhcc_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h2d, q);
  endtask

  task automatic t_pwm;
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h0f);
    pwm <= 0;
    gate(0, 6'h20);
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h0b);
    gate(0, 6'h00);
    pwm <= 1;
    gate(0, 6'h22);
  endtask

  task automatic t_disable;
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h0e);
    gate(0, 6'h00);
    chk("fault_n", 32'h0, {31'h0, flt_n});
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h1e);
    gate(0, 6'h07);
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h0f);
    gate(0, 6'h22);
    chk("fault_n", 32'h1, {31'h0, flt_n});
    uv <= 1;
    gate(0, 6'h00);
    chk("fault_n", 32'h0, {31'h0, flt_n});
    wb(0, bhcc_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h60, q);
    uv <= 0;
    gate(0, 6'h22);
  endtask

  task automatic t_oc;
    cl <= 1;
    @(posedge clk);
    cl <= 0;
    repeat (OS - 3) @(posedge clk);
    chk("gates", 32'h0, {26'h0, g});
    chk("fault_n", 32'h0, {31'h0, flt_n});
    repeat (9) @(posedge clk);
    chk("gates", 32'h22, {26'h0, g});
    cl <= 1;
    repeat (OS + 10) @(posedge clk);
    chk("gates", 32'h0, {26'h0, g});
    wb(0, bhcc_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h30, q);
    wb(0, bhcc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("irq_status", 32'h0f, q);
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h1f);
    repeat (2) @(posedge clk);
    chk("gates", 32'h07, {26'h0, g});
    chk("fault_n", 32'h0, {31'h0, flt_n});
    wb(1, bhcc_pkg::ADDR_CTRL, 32'h0f);
    cl <= 0;
    gate(0, 6'h22);
  endtask

  task automatic t_speed_pulse_out;
    int n;
    n = 0;
    repeat (50) @(posedge clk);
    pos <= 3'h1;
    repeat (60)
    begin
      @(posedge clk);
      if (speed_pulse_out_n === 1'b0)
        n++;
    end
    chk("speed_pulse_out_len", 32'h1, {31'h0, n >= bhcc_pkg::SPEED_PULSE_OUT_CYCLES && n < 60});
  endtask

  task automatic t_irq;
    wb(1, bhcc_pkg::ADDR_IRQ_STATUS, 32'h0f);
    wb(1, bhcc_pkg::ADDR_IRQ_MASK, 32'h01);
    chk("irq", 32'h0, {31'h0, irq});
    pos <= 3'h2;
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wb(0, bhcc_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk("irq_hall", 32'h1, {31'h0, q[0]});
    wb(1, bhcc_pkg::ADDR_IRQ_STATUS, 32'h01);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wb(1, bhcc_pkg::ADDR_IRQ_MASK, 32'h0);
    pos <= 3'h3;
    repeat (4) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 0;
    t_reset();
    t_decode();
    t_pwm();
    t_disable();
    t_oc();
    t_speed_pulse_out();
    t_irq();
    test_done();
  end
endmodule
